// *** common/pio_pkg.sv ***
/*
  Shared constants and types for the pad I/O cell: register map,
  field positions, reset values, set/reset actions and pull choices.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package pio_pkg;

  localparam int PIO_AW = 4;
  localparam logic [3:0] PIO_CTRL_OFF = 4'h0;
  localparam logic [3:0] PIO_POL_OFF  = 4'h4;
  localparam logic [3:0] PIO_STAT_OFF = 4'h8;

  // element indices
  localparam int EL_IN  = 0;
  localparam int EL_OUT = 1;
  localparam int EL_OE  = 2;
  localparam int EL_N   = 3;

  // control register fields
  localparam int CTRL_LATCH = 0;   // 3 bits, one per element
  localparam int CTRL_IREG  = 3;
  localparam int CTRL_OREG  = 4;
  localparam int CTRL_TREG  = 5;
  localparam int CTRL_DLY   = 6;
  localparam int CTRL_KEEP  = 7;
  localparam int CTRL_PULL  = 8;   // 2 bits
  localparam int CTRL_SRM   = 10;  // 2 bits per element
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FFFF;

  // polarity register fields
  localparam int POL_OUT = 0;
  localparam int POL_CLK = 1;
  localparam int POL_CE  = 2;      // 3 bits, one per element
  localparam int POL_SR  = 5;
  localparam int POL_T   = 6;
  localparam logic [31:0] POL_RST  = 32'h0000_0000;
  localparam logic [31:0] POL_MASK = 32'h0000_007F;

  // status register fields
  localparam int STAT_DONE = 0;
  localparam int STAT_PAD  = 1;
  localparam int STAT_Q    = 2;    // 3 bits, one per element
  localparam int STAT_OE   = 5;
  localparam int STAT_WK   = 6;

  localparam logic       ELEM_RST  = 1'b0;
  localparam logic       CLKD_RST  = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;

  typedef enum logic [1:0] {
    SRM_SSET = 2'b00, SRM_SRST = 2'b01, SRM_APRE = 2'b10, SRM_ACLR = 2'b11
  } pio_srm_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'b00, PULL_UP = 2'b01, PULL_DN = 2'b10, PULL_OFF = 2'b11
  } pio_pull_t;

  typedef enum logic [1:0] {
    RG_CTRL = 2'b00, RG_POL = 2'b01, RG_STAT = 2'b10, RG_MISS = 2'b11
  } pio_reg_t;

endpackage

// *** hw/pio_axil.sv ***
/*
  AXI4-Lite slave front end for the pad cell registers. Takes write
  address and data in either order, one write and one read at a time.
  Assumes the register file decodes addresses combinationally.
*/
module pio_axil #(
  parameter int AW = pio_pkg::PIO_AW        // address width
) (
  input  wire logic          clk_sys,       // system clock
  input  wire logic          rst,           // sync reset, high
  input  wire logic [AW-1:0] s_axi_awaddr,  // write address
  input  wire logic          s_axi_awvalid, // write address valid
  output logic               s_axi_awready, // write address ready
  input  wire logic [31:0]   s_axi_wdata,   // write data
  input  wire logic [3:0]    s_axi_wstrb,   // byte enables
  input  wire logic          s_axi_wvalid,  // write data valid
  output logic               s_axi_wready,  // write data ready
  output logic [1:0]         s_axi_bresp,   // write response
  output logic               s_axi_bvalid,  // write response valid
  input  wire logic          s_axi_bready,  // write response ready
  input  wire logic          s_axi_arvalid, // read address valid
  output logic               s_axi_arready, // read address ready
  output logic [31:0]        s_axi_rdata,   // read data
  output logic [1:0]         s_axi_rresp,   // read response
  output logic               s_axi_rvalid,  // read valid
  input  wire logic          s_axi_rready,  // read ready
  output logic               wr_stb,        // register write pulse
  output logic [AW-1:0]      wr_addr,       // register write address
  output logic [31:0]        wr_data,       // register write data
  output logic [3:0]         wr_strb,       // register byte enables
  input  wire logic          wr_err,        // write hits nothing
  input  wire logic [31:0]   rd_data,       // data at read address
  input  wire logic          rd_err         // read hits nothing
);
  import pio_pkg::*;

  logic          aw_full_r, aw_full_nxt;
  logic          w_full_r, w_full_nxt;
  logic          bvalid_r, bvalid_nxt;
  logic          rvalid_r, rvalid_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]   wdata_r, wdata_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic [3:0]    wstrb_r, wstrb_nxt;
  logic [1:0]    bresp_r, bresp_nxt;
  logic [1:0]    rresp_r, rresp_nxt;

  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready  = !w_full_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  // a pending response blocks the next write from committing
  assign wr_stb  = aw_full_r && w_full_r && !bvalid_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    bvalid_nxt  = bvalid_r;
    rvalid_nxt  = rvalid_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bresp_nxt   = bresp_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_stb) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_err ? RESP_SLV : RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_data;
      rresp_nxt  = rd_err ? RESP_SLV : RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      rvalid_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bresp_r   <= bresp_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

endmodule

// *** hw/pio_cell.sv ***
/*
  Pad I/O cell: input, output and enable storage elements on one
  cell clock and one shared set/reset, path selection, input delay,
  keeper and pulls, configured over AXI4-Lite.
  Assumes fabric inputs are synchronous to clk_sys; pad_i is not, and
  the bench resolves the pad wire from pad_oe and wk_oe.
*/
// The register addresses and the AXI4-Lite register port are this design's own decisions.

// Functional notes
// [R1] each element is flop or latch
// [R2] all three elements share one clock
// [R3] each element has its own enable
// [R4] one set/reset shared by all three
// [R5] per element: sync set/reset, async preset/clear
// [R6] pad input direct or through input element
// [R7] optional delay before input element data
// [R8] pad data direct or from output element
// [R9] pad enable direct or from enable element
// [R10] keeper holds last sensed pad level
// [R11] selectable weak pull-up or pull-down
// [R12] independent inversion on output and controls
// [R13] before configuration: pad released, pulls off
// [R14] latch passes while clock and enable active
// [R15] async immediate, sync only on enabled edge; in latch mode sync acts whenever the latch is open
module pio_cell #(
  parameter int DLY_STAGES = 2                 // input delay, >= 2
) (
  input  wire logic                   clk_sys,       // system clock
  input  wire logic                   rst,           // sync reset, high
  input  wire logic [pio_pkg::PIO_AW-1:0] s_axi_awaddr, // write address
  input  wire logic                   s_axi_awvalid, // write addr valid
  output logic                        s_axi_awready, // write addr ready
  input  wire logic [31:0]            s_axi_wdata,   // write data
  input  wire logic [3:0]             s_axi_wstrb,   // byte enables
  input  wire logic                   s_axi_wvalid,  // write data valid
  output logic                        s_axi_wready,  // write data ready
  output logic [1:0]                  s_axi_bresp,   // write response
  output logic                        s_axi_bvalid,  // write resp valid
  input  wire logic                   s_axi_bready,  // write resp ready
  input  wire logic [pio_pkg::PIO_AW-1:0] s_axi_araddr, // read address
  input  wire logic                   s_axi_arvalid, // read addr valid
  output logic                        s_axi_arready, // read addr ready
  output logic [31:0]                 s_axi_rdata,   // read data
  output logic [1:0]                  s_axi_rresp,   // read response
  output logic                        s_axi_rvalid,  // read valid
  input  wire logic                   s_axi_rready,  // read ready
  input  wire logic                   cfg_done,      // configuration done
  input  wire logic                   fab_clk,       // cell clock
  input  wire logic                   fab_sr,        // shared set/reset
  input  wire logic [2:0]             fab_ce,        // enables in/out/oe
  input  wire logic                   fab_o,         // data toward pad
  input  wire logic                   fab_t,         // drive request
  output logic                        fab_i,         // data from pad
  input  wire logic                   pad_i,         // pad level sensed
  output logic                        pad_o,         // pad drive data
  output logic                        pad_oe,        // pad drive enable
  output logic                        wk_o,          // weak drive level
  output logic                        wk_oe          // weak drive enable
);
  import pio_pkg::*;

  logic [31:0]           ctrl_r, ctrl_nxt;
  logic [31:0]           pol_r, pol_nxt;
  logic                  pad_s1_r, pad_s2_r;
  logic [DLY_STAGES-1:0] dly_r, dly_nxt;
  logic                  clkd_r;
  logic                  wk_o_r, wk_o_nxt;
  logic                  wk_oe_r, wk_oe_nxt;
  logic                  wr_stb, wr_err, rd_err;
  logic [PIO_AW-1:0]     wr_addr;
  logic [31:0]           wr_data, rd_data, stat;
  logic [3:0]            wr_strb;
  logic                  clk_lvl, clk_rise, sr;
  logic [EL_N-1:0]       d_v, ce_v, q_v;
  logic                  d_oe;
  pio_pull_t             pull;
  pio_reg_t              wr_sel, rd_sel;

  function automatic pio_reg_t pio_dec(input logic [PIO_AW-1:0] a);
    if (a == PIO_CTRL_OFF) begin
      return RG_CTRL;
    end else if (a == PIO_POL_OFF) begin
      return RG_POL;
    end else if (a == PIO_STAT_OFF) begin
      return RG_STAT;
    end else begin
      return RG_MISS;
    end
  endfunction

  function automatic logic [31:0] pio_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be,
                                            input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////
  pio_axil #(
    .AW (PIO_AW)
  ) u_pio_axil (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wr_sel = pio_dec(wr_addr);
  assign rd_sel = pio_dec(s_axi_araddr);
  assign wr_err = (wr_sel == RG_MISS);
  assign rd_err = (rd_sel == RG_MISS);

  always_comb begin
    stat             = '0;
    stat[STAT_DONE]  = cfg_done;
    stat[STAT_PAD]   = pad_s2_r;
    stat[STAT_Q +: EL_N] = q_v;
    stat[STAT_OE]    = pad_oe;
    stat[STAT_WK]    = wk_oe_r;
    if (rd_sel == RG_CTRL) begin
      rd_data = ctrl_r;
    end else if (rd_sel == RG_POL) begin
      rd_data = pol_r;
    end else if (rd_sel == RG_STAT) begin
      rd_data = stat;
    end else begin
      rd_data = '0;
    end
  end

  // status is read-only; a write there is accepted and dropped
  always_comb begin
    ctrl_nxt = ctrl_r;
    pol_nxt  = pol_r;
    if (wr_stb && wr_sel == RG_CTRL) begin
      ctrl_nxt = pio_merge(ctrl_r, wr_data, wr_strb, CTRL_MASK);
    end
    if (wr_stb && wr_sel == RG_POL) begin
      pol_nxt = pio_merge(pol_r, wr_data, wr_strb, POL_MASK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      pol_r  <= POL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      pol_r  <= pol_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pad input: two-flop synchroniser, then the optional delay line
  assign dly_nxt = {dly_r[DLY_STAGES-2:0], pad_s2_r};
  assign pull    = pio_pull_t'(ctrl_r[CTRL_PULL +: 2]);

  always_comb begin
    wk_oe_nxt = 1'b0;
    wk_o_nxt  = 1'b0;
    if (cfg_done && ctrl_r[CTRL_KEEP]) begin
      wk_oe_nxt = 1'b1;
      wk_o_nxt  = pad_s2_r;                     // [R10]
    end else if (cfg_done && pull == PULL_UP) begin
      wk_oe_nxt = 1'b1;
      wk_o_nxt  = 1'b1;                         // [R11]
    end else if (cfg_done && pull == PULL_DN) begin
      wk_oe_nxt = 1'b1;                         // [R11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pad_s1_r <= 1'b0;
      pad_s2_r <= 1'b0;
      dly_r    <= '0;
      clkd_r   <= CLKD_RST;
      wk_o_r   <= 1'b0;
      wk_oe_r  <= 1'b0;
    end else begin
      pad_s1_r <= pad_i;
      pad_s2_r <= pad_s1_r;
      dly_r    <= dly_nxt;
      clkd_r   <= clk_lvl;
      wk_o_r   <= wk_o_nxt;
      wk_oe_r  <= wk_oe_nxt;
    end
  end

  assign wk_o  = wk_o_r;
  assign wk_oe = wk_oe_r;

  ////////////////////////////////////////////////////////////////////
  // one cell clock and one set/reset serve all three elements
  assign clk_lvl  = fab_clk ^ pol_r[POL_CLK];          // [R2] [R12]
  assign clk_rise = clk_lvl && !clkd_r;                // [R2]
  assign sr       = fab_sr ^ pol_r[POL_SR];            // [R4] [R12]
  assign d_oe     = fab_t ^ pol_r[POL_T];              // [R12]

  assign d_v[EL_IN]  = ctrl_r[CTRL_DLY] ? dly_r[DLY_STAGES-1]
                                        : pad_s2_r;   // [R7]
  assign d_v[EL_OUT] = fab_o;
  assign d_v[EL_OE]  = d_oe;

  generate
    for (genvar i = 0; i < EL_N; i++) begin : g_el
      assign ce_v[i] = fab_ce[i] ^ pol_r[POL_CE + i];  // [R3] [R12]
      pio_elem u_pio_elem (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .clk_lvl    (clk_lvl),
        .clk_rise   (clk_rise),
        .ce         (ce_v[i]),
        .sr         (sr),
        .d          (d_v[i]),
        .latch_mode (ctrl_r[CTRL_LATCH + i]),
        .sr_mode    (pio_srm_t'(ctrl_r[CTRL_SRM + 2*i +: 2])),
        .q          (q_v[i])
      );
    end
  endgenerate

  // pad stays released until configuration completes
  assign fab_i  = ctrl_r[CTRL_IREG] ? q_v[EL_IN] : pad_s2_r;      // [R6]
  assign pad_o  = (ctrl_r[CTRL_OREG] ? q_v[EL_OUT] : fab_o)
                  ^ pol_r[POL_OUT];                              // [R8] [R12]
  assign pad_oe = cfg_done
                  && (ctrl_r[CTRL_TREG] ? q_v[EL_OE] : d_oe);    // [R9] [R13]

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_keep_on;
    cfg_done && ctrl_r[CTRL_KEEP];
  endsequence

  sequence s_pull_up_on;
    cfg_done && !ctrl_r[CTRL_KEEP] && pull == PULL_UP;
  endsequence

  property p_preconfig;
    !cfg_done |-> !pad_oe ##1 !wk_oe;
  endproperty
  a_preconfig: assert property (p_preconfig) else $error("pad active before config"); // [R13]

  property p_keeper;
    s_keep_on |=> wk_oe && wk_o == $past(pad_s2_r);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper lost last level"); // [R10]

  property p_pull_up;
    s_pull_up_on |=> wk_oe && wk_o;
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up not applied"); // [R11]

  property p_in_direct;
    !ctrl_r[CTRL_IREG] |-> fab_i == pad_s2_r;
  endproperty
  a_in_direct: assert property (p_in_direct) else $error("direct input wrong"); // [R6]

  property p_delay;
    ctrl_r[CTRL_DLY] |-> d_v[EL_IN] == $past(pad_s2_r, DLY_STAGES);
  endproperty
  a_delay: assert property (p_delay) else $error("input delay wrong"); // [R7]

  property p_out_reg;
    ctrl_r[CTRL_OREG] |-> pad_o == (q_v[EL_OUT] ^ pol_r[POL_OUT]);
  endproperty
  a_out_reg: assert property (p_out_reg) else $error("registered output wrong"); // [R8]

  property p_oe_reg;
    cfg_done && ctrl_r[CTRL_TREG] |-> pad_oe == q_v[EL_OE];
  endproperty
  a_oe_reg: assert property (p_oe_reg) else $error("registered enable wrong"); // [R9]

  property p_common_clk;
    clk_rise |-> ##1 !clk_rise;
  endproperty
  a_common_clk: assert property (p_common_clk) else $error("clock edge doubled"); // [R2]

endmodule

// *** hw/pio_elem.sv ***
/*
  One storage element of the pad cell: flip-flop or latch, with a
  clock enable and a shared set/reset of selectable action.
  Assumes clk_lvl and clk_rise derive from one cell clock on clk_sys.
*/
module pio_elem (
  input  wire logic             clk_sys,    // system clock
  input  wire logic             rst,        // sync reset, high
  input  wire logic             clk_lvl,    // cell clock level
  input  wire logic             clk_rise,   // cell clock edge pulse
  input  wire logic             ce,         // clock enable
  input  wire logic             sr,         // shared set/reset
  input  wire logic             d,          // data in
  input  wire logic             latch_mode, // 1 = latch
  input  wire pio_pkg::pio_srm_t sr_mode,   // set/reset action
  output logic                  q           // element output
);
  import pio_pkg::*;

  logic q_r;
  logic q_nxt;
  logic is_async;
  logic aval;
  logic sval;
  logic open_now;

  assign is_async = (sr_mode == SRM_APRE) || (sr_mode == SRM_ACLR);
  assign aval     = (sr_mode == SRM_APRE);
  assign sval     = (sr_mode == SRM_SSET);
  assign open_now = latch_mode && clk_lvl && ce;

  always_comb begin
    q_nxt = q_r;
    if (sr && is_async) begin
      q_nxt = aval;                              // [R15]
    end else if (latch_mode) begin
      if (open_now) begin
        q_nxt = sr ? sval : d;                   // [R14]
      end
    end else if (clk_rise && ce) begin
      q_nxt = sr ? sval : d;                     // [R1] [R5]
    end
  end

  // async action and open latch show at once, not one cycle late
  always_comb begin
    q = q_r;
    if (sr && is_async) begin
      q = aval;                                  // [R15]
    end else if (open_now) begin
      q = sr ? sval : d;                         // [R14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_r <= ELEM_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_edge_sync;
    !latch_mode && clk_rise && ce && sr && !is_async;
  endsequence

  property p_async_force;
    sr && is_async |-> q == aval ##1 (q_r == $past(aval));
  endproperty
  a_async_force: assert property (p_async_force) else $error("async set/reset not forced"); // [R15]

  property p_sync_edge;
    s_edge_sync |=> q_r == $past(sval);
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync set/reset missed"); // [R5]

  property p_hold_no_ce;
    !latch_mode && !ce && !(sr && is_async) |=> $stable(q_r);
  endproperty
  a_hold_no_ce: assert property (p_hold_no_ce) else $error("disabled element changed"); // [R3]

  property p_ff_capture;
    !latch_mode && clk_rise && ce && !sr |=> q_r == $past(d);
  endproperty
  a_ff_capture: assert property (p_ff_capture) else $error("flop did not capture"); // [R1]

  property p_latch_pass;
    latch_mode && clk_lvl && ce && !sr |-> q == d;
  endproperty
  a_latch_pass: assert property (p_latch_pass) else $error("latch not transparent"); // [R14]

endmodule

// *** tb/pio_pad_model.sv ***
/*
  Far side of the pad: resolves the pad wire from the cell's strong
  and weak drivers and an external driver owned by the bench.
  Assumes the cell's pad outputs are settled between clk_sys edges.
*/
module pio_pad_model (
  input  wire logic clk_sys, // system clock
  input  wire logic pad_o,   // strong data
  input  wire logic pad_oe,  // strong enable
  input  wire logic wk_o,    // weak data
  input  wire logic wk_oe,   // weak enable
  input  wire logic ext_en,  // external driver on
  input  wire logic ext_v,   // external level
  output logic      pad_i    // resolved level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_r = 1'h0;
  always_ff @(posedge clk_sys) begin
    last_r <= pad_i;
  end
  // an undriven wire must not look stable, so it wanders
  assign pad_i = pad_oe ? pad_o : wk_oe ? wk_o : ext_en ? ext_v : ~last_r;
endmodule

// *** tb/tb_pad_io_cell_registers.sv ***
/*
  Self-checking bench for the pad cell: registers over AXI4-Lite,
  paths, storage elements, set/reset, inversion, pull and keeper.
  Assumes the cell's default delay depth.
*/
module tb_pad_io_cell_registers;
  timeunit 1ns;
  timeprecision 1ns;
  import pio_pkg::*;
  logic        clk_sys = 1'h0, rst = 1'h1, cfg_done = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        fab_clk = 1'h0, fab_sr = 1'h0, fab_o = 1'h0, fab_t = 1'h0;
  logic        ext_en = 1'h0, ext_v = 1'h0;
  logic [2:0]  fab_ce = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, fab_i, pad_i, pad_o, pad_oe;
  logic        wk_o, wk_oe;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0, check_count = 0, cyc = 0;
  pio_cell u_pio_cell (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfg_done(cfg_done), .fab_clk(fab_clk), .fab_sr(fab_sr), .fab_ce(fab_ce),
    .fab_o(fab_o), .fab_t(fab_t), .fab_i(fab_i), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe(pad_oe), .wk_o(wk_o), .wk_oe(wk_oe));
  pio_pad_model u_pio_pad_model (.clk_sys(clk_sys), .pad_o(pad_o), .pad_oe(pad_oe),
    .wk_o(wk_o), .wk_oe(wk_oe), .ext_en(ext_en), .ext_v(ext_v), .pad_i(pad_i));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    // local flags: awv and wv still read their old value in this step
    while (pa || pw) begin
      @(posedge clk_sys);
      if (pa && awready) begin
        pa = 1'h0;
        awv <= 1'h0;
      end
      if (pw && wready) begin
        pw = 1'h0;
        wv <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'h0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [1:0] er);
    araddr <= a;
    arv <= 1'h1;
    do @(posedge clk_sys); while (!arready);
    arv <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk_sys); while (!rvalid);
    rready <= 1'h0;
    chk(rdata, ex);
    chk(rresp, er);
  endtask
  task automatic tick;
    fab_clk <= 1'h1;
    wt(2);
    fab_clk <= 1'h0;
    wt(3);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    wt(12);
    rst <= 1'h0;
    fab_t <= 1'h1;
    fab_o <= 1'h1;
    wt(3);
    chk({pad_oe, wk_oe}, 2'h0);
    rd(PIO_CTRL_OFF, CTRL_RST, RESP_OKAY);
    rd(PIO_POL_OFF, POL_RST, RESP_OKAY);
    rd(4'hC, 32'h0, RESP_SLV);
    wr(4'hC, 32'h1, RESP_SLV);
    cfg_done <= 1'h1;
    wt(2);
    chk({pad_oe, pad_o}, 2'h3);
    wr(PIO_POL_OFF, 32'h41, RESP_OKAY);
    chk({pad_oe, pad_o}, 2'h0);
    wr(PIO_POL_OFF, 32'h0, RESP_OKAY);
    // registered output, async clear on the shared set/reset
    wr(PIO_CTRL_OFF, 32'h3010, RESP_OKAY);
    tick();
    chk(pad_o, 1'h0);
    fab_ce <= 3'h2;
    tick();
    chk(pad_o, 1'h1);
    fab_sr <= 1'h1;
    wt(1);
    chk(pad_o, 1'h0);
    fab_sr <= 1'h0;
    wr(PIO_CTRL_OFF, 32'h3012, RESP_OKAY);
    fab_clk <= 1'h1;
    wt(2);
    chk(pad_o, 1'h1);
    fab_clk <= 1'h0;
    wt(1);
    fab_o <= 1'h0;
    wt(2);
    chk(pad_o, 1'h1);
    // sync set: no effect until an enabled cell edge
    wr(PIO_CTRL_OFF, 32'h0010, RESP_OKAY);
    tick();
    fab_sr <= 1'h1;
    wt(2);
    chk(pad_o, 1'h0);
    tick();
    chk(pad_o, 1'h1);
    fab_sr <= 1'h0;
    // registered enable, clocked through an inverted enable
    wr(PIO_CTRL_OFF, 32'h20, RESP_OKAY);
    wr(PIO_POL_OFF, 32'h10, RESP_OKAY);
    chk(pad_oe, 1'h0);
    tick();
    chk(pad_oe, 1'h1);
    wr(PIO_POL_OFF, 32'h0, RESP_OKAY);
    // input side: direct, then registered behind the delay
    fab_t <= 1'h0;
    ext_en <= 1'h1;
    ext_v <= 1'h1;
    wr(PIO_CTRL_OFF, 32'h0, RESP_OKAY);
    wt(4);
    chk(fab_i, 1'h1);
    wr(PIO_CTRL_OFF, 32'h48, RESP_OKAY);
    fab_ce <= 3'h1;
    wt(6);
    tick();
    chk(fab_i, 1'h1);
    ext_v <= 1'h0;
    wt(4);
    chk(fab_i, 1'h1);
    ext_en <= 1'h0;
    wr(PIO_CTRL_OFF, 32'h100, RESP_OKAY);
    wt(5);
    chk({wk_oe, wk_o, fab_i}, 3'h7);
    wr(PIO_CTRL_OFF, 32'h200, RESP_OKAY);
    wt(5);
    chk({wk_oe, wk_o, fab_i}, 3'h4);
    wr(PIO_CTRL_OFF, 32'h0, RESP_OKAY);
    ext_en <= 1'h1;
    ext_v <= 1'h1;
    wt(4);
    wr(PIO_CTRL_OFF, 32'h80, RESP_OKAY);
    ext_en <= 1'h0;
    wt(6);
    chk({wk_oe, wk_o, fab_i}, 3'h7);
    conclude();
  end
endmodule
